/* File: teio_cfg.svh */
`ifndef TEIO_CFG_SVH
`define TEIO_CFG_SVH
// =====================================================================
// Clock and time base
`define TEIO_CLK_PERIOD_NS  100
`define TEIO_MS_NS          1000000
`define TEIO_MEAS_CYC       200
`define TEIO_PRE_W          14
// =====================================================================
// Register byte offsets
`define TEIO_A_CTRL         8'h00
`define TEIO_A_DELAY        8'h04
`define TEIO_A_PULSE        8'h08
`define TEIO_A_OUT          8'h0c
`define TEIO_A_INEDGE       8'h10
`define TEIO_A_CMD          8'h14
`define TEIO_A_STATUS       8'h18
// =====================================================================
// Command register bits
`define TEIO_C_ARM          0
`define TEIO_C_BUSTRG       1
`define TEIO_C_READ         2
`define TEIO_C_LOCAL        3
`define TEIO_C_SYSRST       4
`define TEIO_C_BACKUP       5
`define TEIO_C_SAVE         6
`define TEIO_C_LOAD         7
`define TEIO_C_SLOT_LO      8
`define TEIO_C_SLOT_HI      14
// =====================================================================
// Limits and factory defaults
`define TEIO_SLOTS          7'd126
`define TEIO_DELAY_MAX      14'd9999
`define TEIO_PULSE_MIN      7'd1
`define TEIO_PULSE_MAX      7'd99
`define TEIO_PULSE_DEF      7'd5
`define TEIO_CTRL_DEF       9'h040
`define TEIO_IN_BITS        5
`define TEIO_OUT_BITS       10
`endif

/* File: teio_handler_model.sv */
`timescale 1ns/100ps
// =====================================================
// Handler side: shorts input lines for three cycles
module teio_handler_model (
    // Clock and request
    input  wire logic       mclk,
    input  wire logic [5:0] req,
    // Lines towards the block
    output logic [4:0]      extIn,
    output logic            panelKey
);
    logic [1:0] hold;
    // Released lines read open (0), never the last level
    always @(posedge mclk) begin
        if (req != 6'h00) begin
            {panelKey, extIn} <= req;
            hold <= 2'h2;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end else begin
            {panelKey, extIn} <= 6'h00;
        end
    end
    initial {panelKey, extIn, hold} = 8'h00;
endmodule // teio_handler_model

/* File: teio_pkg.sv */
package teio_pkg;
    // =================================================================
    // Settings image, bit order matches the control register
    typedef struct packed {
        logic [13:0] delayMs;
        logic [6:0]  pulseMs;
        logic        delayEn;      // ctrl bit 8
        logic        trigExt;      // ctrl bit 7
        logic        continuous;   // ctrl bit 6
        logic        currentPulse; // ctrl bit 5
        logic        strobePulse;  // ctrl bit 4
        logic        termCr;       // ctrl bit 3
        logic        errSync;      // ctrl bit 2
        logic        headerEn;     // ctrl bit 1
        logic        extIoLock;    // ctrl bit 0
    } teio_cfg_t;

    // Trigger sequence states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_DELAY = 3'b010,
        ST_MEAS  = 3'b011,
        ST_CALC  = 3'b100,
        ST_OUT   = 3'b101
    } teio_state_t;
endpackage

/* File: teio_trigger_io.sv */
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "teio_cfg.svh"
// Functional notes
// RL1 - Lock on: ignore external input line actions
// RL2 - Save/recall 126 slots; empty recall errors
// RL3 - Header setting selects response header prefix
// RL4 - Error report synced to strobe or independent
// RL5 - Terminator code 0 LF, 1 CR LF
// RL6 - Hold mode: strobe until next measurement starts
// RL7 - Pulse mode: strobe width 1 to 99 ms
// RL8 - Pulse current forced continuous in free run
// RL9 - System reset restores defaults, keeps communication
// RL10 - Output value 0..1023 onto ten lines
// RL11 - Five sticky input edges, cleared on read
// RL12 - Key and bus trigger set trigger edge
// RL13 - Continuous: back to wait, internal free-runs
// RL14 - Not continuous: idle after each measurement
// RL15 - Idle ignores triggers; arm enters trigger wait
// RL16 - Arm while continuous: error, no change
// RL17 - Continuous off only remotely; on at local
// RL18 - External source: line, key, bus trigger
// RL19 - Bus trigger ignored during measure-and-read wait
// RL20 - Delay enable inserts delay before measurement
// RL21 - Local command returns to panel control
// RL22 - Backup writes settings to non-volatile image
// RL23 - Trigger delay 0 to 9.999 seconds
// RL24 - Delay, measure, calculate, output, then strobe
module teio_trigger_io #(
    parameter int MS_CYC   = `TEIO_MS_NS / `TEIO_CLK_PERIOD_NS,
    parameter int MEAS_CYC = `TEIO_MEAS_CYC
) (
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       rst,
    // AHB-Lite slave
    input  wire logic                       hsel,
    input  wire logic [31:0]                haddr,
    input  wire logic [1:0]                 htrans,
    input  wire logic                       hwrite,
    input  wire logic [2:0]                 hsize,
    input  wire logic [31:0]                hwdata,
    input  wire logic                       hready,
    output logic                            hreadyout,
    output logic [31:0]                     hrdata,
    output logic                            hresp,
    // External I/O and panel
    input  wire logic [`TEIO_IN_BITS-1:0]   extIn,
    input  wire logic                       panelKey,
    output logic [`TEIO_OUT_BITS-1:0]       extOut,
    output logic                            measureDoneStrobe,
    output logic                            errLine,
    output logic                            currentPulseOut,
    output logic                            rspHeader,
    output logic                            rspTermCr,
    // Non-volatile image
    input  wire teio_pkg::teio_cfg_t        nvImage,
    input  wire logic                       nvValid,
    output teio_pkg::teio_cfg_t             nvData,
    output logic                            nvStore
);
    import teio_pkg::*;

    // =================================================================
    // Bus front end
    logic        aValid;
    logic        aWrite;
    logic [7:0]  aAddr;
    logic        rdAcc;
    logic        wrAcc;
    logic [31:0] next_rdata;

    assign rdAcc = hsel & htrans[1] & hready & ~hwrite;
    assign wrAcc = aValid & aWrite;

    // Address phase capture; no wait states, so hready is ours
    always_ff @(posedge mclk) begin
        if (rst) begin
            aValid <= 1'b0;
            aWrite <= 1'b0;
            aAddr  <= 8'h00;
        end else if (hready) begin
            aValid <= hsel & htrans[1];
            aWrite <= hwrite;
            aAddr  <= haddr[7:0];
        end
    end

    // =================================================================
    // Command decode
    logic       wrCmd;
    logic       cmdArm, cmdBusHit, cmdRead, cmdLocal;
    logic       cmdSysRst, cmdBackup, cmdSave, cmdLoad;
    logic [6:0] slot;
    logic       slotOk;

    assign wrCmd     = wrAcc && aAddr == `TEIO_A_CMD;
    assign cmdArm    = wrCmd & hwdata[`TEIO_C_ARM];
    assign cmdBusHit = wrCmd & hwdata[`TEIO_C_BUSTRG];
    assign cmdRead   = wrCmd & hwdata[`TEIO_C_READ];
    assign cmdLocal  = wrCmd & hwdata[`TEIO_C_LOCAL];
    assign cmdSysRst = wrCmd & hwdata[`TEIO_C_SYSRST];
    assign cmdBackup = wrCmd & hwdata[`TEIO_C_BACKUP];
    assign cmdSave   = wrCmd & hwdata[`TEIO_C_SAVE];
    assign cmdLoad   = wrCmd & hwdata[`TEIO_C_LOAD];
    assign slot      = hwdata[`TEIO_C_SLOT_HI:`TEIO_C_SLOT_LO];
    assign slotOk    = slot != 7'd0 && slot <= `TEIO_SLOTS;

    // =================================================================
    // Settings, panel store and remote state
    teio_cfg_t   cfg;
    teio_cfg_t   panelMem [1:126];
    logic [126:1] panelValid;
    logic        remote;
    logic        nvPending;
    logic        badWrite;
    logic        loadOk;

    assign loadOk = cmdLoad & slotOk && panelValid[slot];

    // Out-of-range values are refused, not clipped
    always_comb begin
        badWrite = 1'b0;
        if (wrAcc && aAddr == `TEIO_A_DELAY)
            badWrite = hwdata[31:14] != 18'h0 ||
                       hwdata[13:0] > `TEIO_DELAY_MAX;                // [RL23]
        else if (wrAcc && aAddr == `TEIO_A_PULSE)
            badWrite = hwdata[31:7] != 25'h0 ||
                       hwdata[6:0] < `TEIO_PULSE_MIN ||
                       hwdata[6:0] > `TEIO_PULSE_MAX;                 // [RL7]
        else if (wrAcc && aAddr == `TEIO_A_OUT)
            badWrite = hwdata[31:10] != 22'h0;                        // [RL10]
    end

    // Saved image is brought in one cycle after reset release
    always_ff @(posedge mclk) begin
        if (rst) begin
            nvPending <= 1'b1;
            cfg       <= '{delayMs: 14'h0, pulseMs: `TEIO_PULSE_DEF,
                           default: 1'b0};
            cfg[8:0]  <= `TEIO_CTRL_DEF;                              // [RL17]
        end else begin
            nvPending <= 1'b0;
            if (nvPending && nvValid) begin
                cfg            <= nvImage;                            // [RL22]
                cfg.continuous <= 1'b1;                               // [RL17]
            end else if (cmdSysRst) begin
                cfg         <= '{delayMs: 14'h0, pulseMs: `TEIO_PULSE_DEF,
                                 default: 1'b0};
                cfg[8:0]    <= `TEIO_CTRL_DEF;                        // [RL9]
                cfg.termCr  <= cfg.termCr;                            // [RL9]
            end else if (cmdLocal) begin
                cfg.continuous <= 1'b1;                               // [RL17]
            end else if (loadOk) begin
                cfg        <= panelMem[slot];                         // [RL2]
                cfg.termCr <= cfg.termCr;
            end else if (wrAcc && !badWrite) begin
                case (aAddr)
                    `TEIO_A_CTRL:  cfg[8:0]    <= hwdata[8:0];
                    `TEIO_A_DELAY: cfg.delayMs <= hwdata[13:0];
                    `TEIO_A_PULSE: cfg.pulseMs <= hwdata[6:0];
                    default: ;
                endcase
            end
        end
    end

    // Panel slots; store itself is not reset, only its valid flags
    always_ff @(posedge mclk) begin
        if (cmdSave && slotOk)
            panelMem[slot] <= cfg;                                    // [RL2]
    end

    always_ff @(posedge mclk) begin
        if (rst || cmdSysRst)
            panelValid <= '0;                                         // [RL9]
        else if (cmdSave && slotOk)
            panelValid[slot] <= 1'b1;
    end

    // Any bus write except a local command puts the block under remote control
    always_ff @(posedge mclk) begin
        if (rst)
            remote <= 1'b0;
        else if (cmdLocal)
            remote <= 1'b0;                                           // [RL21]
        else if (wrAcc)
            remote <= 1'b1;
    end

    // Backup image and store strobe toward the non-volatile memory
    always_ff @(posedge mclk) begin
        if (rst) begin
            nvStore <= 1'b0;
            nvData  <= '0;
        end else begin
            nvStore <= cmdBackup;                                     // [RL22]
            if (cmdBackup)
                nvData <= cfg;
        end
    end

    // =================================================================
    // Input edge latches
    logic [`TEIO_IN_BITS-1:0] prevIn;
    logic [`TEIO_IN_BITS-1:0] inRise;
    logic [`TEIO_IN_BITS-1:0] inEdge;
    logic                     prevKey;
    logic                     keyRise;
    logic                     clrEdge;

    assign keyRise = panelKey & ~prevKey;
    assign clrEdge = rdAcc && haddr[7:0] == `TEIO_A_INEDGE;

    genvar gi;
    generate
        for (gi = 0; gi < `TEIO_IN_BITS; gi++) begin : g_edge
            logic extra;
            assign extra      = gi == 0 ? keyRise | cmdBusHit : 1'b0; // [RL12]
            assign inRise[gi] = extIn[gi] & ~prevIn[gi];
            // New edge beats the clear of a read in the same cycle
            always_ff @(posedge mclk) begin
                if (rst) begin
                    prevIn[gi] <= 1'b0;
                    inEdge[gi] <= 1'b0;
                end else begin
                    prevIn[gi] <= extIn[gi];
                    if (inRise[gi] | extra)
                        inEdge[gi] <= 1'b1;                           // [RL11]
                    else if (clrEdge)
                        inEdge[gi] <= 1'b0;                           // [RL11]
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst)
            prevKey <= 1'b0;
        else
            prevKey <= panelKey;
    end

    // =================================================================
    // Trigger sequencer
    teio_state_t            state;
    logic                   readPending;
    logic                   armOk;
    logic                   trigHit;
    logic                   go;
    logic                   startMeas;
    logic [`TEIO_PRE_W-1:0] pre;
    logic [13:0]            cnt;
    logic                   msTick;

    assign armOk   = (cmdArm | cmdRead) & ~cfg.continuous;            // [RL16]
    assign trigHit = (inRise[0] & ~cfg.extIoLock)                     // [RL1]
                   | keyRise
                   | (cmdBusHit & ~readPending);                      // [RL19]
    assign go        = cfg.trigExt ? trigHit : 1'b1;                  // [RL18]
    assign startMeas = state == ST_WAIT && go;
    assign msTick    = pre == `TEIO_PRE_W'(MS_CYC - 1);

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_WAIT;
            pre   <= '0;
            cnt   <= 14'h0;
        end else begin
            pre <= (state == ST_DELAY && !msTick) ? pre + 1'b1 : '0;
            case (state)
                ST_IDLE: begin
                    if (armOk || cfg.continuous)
                        state <= ST_WAIT;                             // [RL15]
                end
                ST_WAIT: begin
                    cnt <= 14'h0;
                    if (go)
                        state <= cfg.delayEn ? ST_DELAY : ST_MEAS;    // [RL20]
                end
                ST_DELAY: begin
                    if (cnt >= cfg.delayMs) begin
                        state <= ST_MEAS;                             // [RL24]
                        cnt   <= 14'h0;
                    end else if (msTick)
                        cnt <= cnt + 14'h1;
                end
                ST_MEAS: begin
                    cnt <= cnt + 14'h1;
                    if (cnt == 14'(MEAS_CYC - 1))
                        state <= ST_CALC;                             // [RL24]
                end
                ST_CALC: state <= ST_OUT;                             // [RL24]
                ST_OUT: begin
                    if (cfg.continuous)
                        state <= ST_WAIT;                             // [RL13]
                    else
                        state <= ST_IDLE;                             // [RL14]
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Measure-and-read wait blocks the bus trigger until output
    always_ff @(posedge mclk) begin
        if (rst)
            readPending <= 1'b0;
        else if (cmdRead && armOk)
            readPending <= 1'b1;
        else if (state == ST_OUT)
            readPending <= 1'b0;
    end

    // =================================================================
    // Done strobe, hold or timed pulse
    logic [`TEIO_PRE_W-1:0] sPre;
    logic [6:0]             sMs;

    always_ff @(posedge mclk) begin
        if (rst) begin
            measureDoneStrobe <= 1'b0;
            sPre              <= '0;
            sMs               <= 7'h0;
        end else if (state == ST_OUT) begin
            measureDoneStrobe <= 1'b1;                                // [RL24]
            sPre              <= '0;
            sMs               <= 7'h0;
        end else if (startMeas) begin
            measureDoneStrobe <= 1'b0;                                // [RL6]
        end else if (measureDoneStrobe && cfg.strobePulse) begin
            if (sPre == `TEIO_PRE_W'(MS_CYC - 1)) begin
                sPre <= '0;
                sMs  <= sMs + 7'h1;
                if (sMs + 7'h1 >= cfg.pulseMs)
                    measureDoneStrobe <= 1'b0;                        // [RL7]
            end else
                sPre <= sPre + 1'b1;
        end
    end

    // =================================================================
    // Error reporting and status
    logic execErr;
    logic errEvent;
    logic errHeld;
    logic clrStat;

    assign errEvent = ((cmdArm | cmdRead) & cfg.continuous)           // [RL16]
                    | (cmdLoad & ~loadOk)                             // [RL2]
                    | ((cmdSave | cmdLoad) & ~slotOk)
                    | badWrite;
    assign clrStat  = rdAcc && haddr[7:0] == `TEIO_A_STATUS;

    // Set wins over a status read in the same cycle
    always_ff @(posedge mclk) begin
        if (rst)
            execErr <= 1'b0;
        else if (errEvent)
            execErr <= 1'b1;
        else if (clrStat)
            execErr <= 1'b0;
    end

    // Synchronous mode holds the report until the strobe rises
    always_ff @(posedge mclk) begin
        if (rst) begin
            errHeld <= 1'b0;
            errLine <= 1'b0;
        end else if (cfg.errSync) begin
            errLine <= errHeld && state == ST_OUT;                    // [RL4]
            if (errEvent)
                errHeld <= 1'b1;
            else if (state == ST_OUT)
                errHeld <= 1'b0;
        end else begin
            errLine <= errEvent;                                      // [RL4]
            errHeld <= 1'b0;
        end
    end

    // =================================================================
    // Driven lines and formatter selects
    always_ff @(posedge mclk) begin
        if (rst || cmdSysRst)
            extOut <= '0;
        else if (wrAcc && aAddr == `TEIO_A_OUT && !badWrite)
            extOut <= hwdata[`TEIO_OUT_BITS-1:0];                     // [RL10]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            currentPulseOut <= 1'b0;
            rspHeader       <= 1'b0;
            rspTermCr       <= 1'b0;
        end else begin
            currentPulseOut <= cfg.currentPulse &
                               ~(cfg.continuous & ~cfg.trigExt);      // [RL8]
            rspHeader       <= cfg.headerEn;                          // [RL3]
            rspTermCr       <= cfg.termCr;                            // [RL5]
        end
    end

    // =================================================================
    // Read mux; unmapped reads give zero with OKAY
    always_comb begin
        next_rdata = 32'h0;
        case (haddr[7:0])
            `TEIO_A_CTRL:   next_rdata[8:0]  = cfg[8:0];
            `TEIO_A_DELAY:  next_rdata[13:0] = cfg.delayMs;
            `TEIO_A_PULSE:  next_rdata[6:0]  = cfg.pulseMs;
            `TEIO_A_OUT:    next_rdata[9:0]  = extOut;
            `TEIO_A_INEDGE: next_rdata[4:0]  = inEdge;                // [RL11]
            `TEIO_A_STATUS: next_rdata[7:0]  = {readPending, remote,
                                measureDoneStrobe, execErr, 1'b0, state};
            default:        next_rdata       = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rdAcc)
                hrdata <= next_rdata;
        end
    end

    // =================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    lock_gate_a: assert property (                                    // [RL1]
        state == ST_WAIT && cfg.trigExt && cfg.extIoLock && !keyRise &&
        !cmdBusHit |=> state == ST_WAIT)
        else $error("locked line triggered");
    load_empty_a: assert property (                                   // [RL2]
        cmdLoad && !loadOk && !nvPending |=> execErr && cfg == $past(cfg))
        else $error("empty slot load changed settings");
    hold_strobe_a: assert property (                                  // [RL6]
        measureDoneStrobe && !cfg.strobePulse && !startMeas
        |=> measureDoneStrobe)
        else $error("hold strobe dropped early");
    cur_force_a: assert property (                                    // [RL8]
        cfg.continuous && !cfg.trigExt |=> !currentPulseOut)
        else $error("pulse current in free run");
    out_lines_a: assert property (                                    // [RL10]
        wrAcc && aAddr == `TEIO_A_OUT && hwdata[31:10] == 22'h0
        |=> extOut == $past(hwdata[9:0]))
        else $error("output lines not updated");
    edge_clear_a: assert property (                                   // [RL11]
        clrEdge && inRise == '0 && !keyRise && !cmdBusHit |=> inEdge == '0)
        else $error("edge bits not cleared");
    idle_ign_a: assert property (                                     // [RL15]
        state == ST_IDLE && !armOk && !cfg.continuous |=> state == ST_IDLE)
        else $error("idle left without arm");
    arm_reject_a: assert property (                                   // [RL16]
        cmdArm && cfg.continuous |=> execErr)
        else $error("arm in continuous not rejected");
    done_idle_a: assert property (                                    // [RL14]
        state == ST_OUT && !cfg.continuous |=> state == ST_IDLE)
        else $error("no idle after single measurement");
    strobe_src_a: assert property (                                   // [RL24]
        $rose(measureDoneStrobe) |-> $past(state) == ST_OUT)
        else $error("strobe not at end of sequence");

    free_run_c: cover property (state == ST_OUT ##1 state == ST_WAIT ##1
                                state == ST_MEAS);
    pulse_end_c: cover property (cfg.strobePulse ##0
                                 $fell(measureDoneStrobe));
    load_ok_c: cover property (loadOk);
endmodule // teio_trigger_io

/* File: teio_trigger_io_tb.sv */
`timescale 1ns/100ps
`include "teio_cfg.svh"
module teio_trigger_io_tb;
    logic mclk = 0, rst = 1, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic hreadyout, strobe;
    logic hdr, termCr, curPulse, errLine, nvStore;
    logic [29:0] nvData;
    logic [5:0] req = 0;
    logic [4:0] extIn;
    logic panelKey;
    logic [9:0] extOut;
    int errTotal = 0, cmpCount = 0, n;
    always #50 mclk = ~mclk;
    teio_handler_model hm (.mclk(mclk), .req(req), .extIn(extIn),
        .panelKey(panelKey));
    teio_trigger_io #(.MS_CYC(10), .MEAS_CYC(8)) uut (.mclk(mclk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .extIn(extIn),
        .panelKey(panelKey), .extOut(extOut), .measureDoneStrobe(strobe),
        .errLine(errLine), .currentPulseOut(curPulse), .rspHeader(hdr),
        .rspTermCr(termCr), .nvImage('0), .nvValid(1'b0), .nvData(nvData),
        .nvStore(nvStore));
    task automatic tick(int k = 1);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // One single word transfer, address then data phase
    task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge mclk);
        {hsel, htrans, hwrite, haddr} <= {3'b110, wr, 24'h0, a};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {3'b000, d};
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic chk(logic [31:0] s, logic [31:0] e);
        cmpCount++;
        if (s !== e) begin
            errTotal++;
            $display("ERROR t=%0t got=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic press(logic [5:0] m);
        req <= m;
        tick();
        req <= 6'h00;
        tick(6);
    endtask
    task automatic state(logic [2:0] e);
        bus(0, `TEIO_A_STATUS, 0);
        chk(q[2:0], e);
    endtask
    task automatic summarize;
        $display("cmp=%0d err=%0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Output lines and out-of-range value
    task automatic t_out;
        bus(1, `TEIO_A_OUT, 32'h201); tick(); chk(extOut, 10'h201);
        bus(1, `TEIO_A_OUT, 32'h400); #1 chk(errLine, 1'b1);
        tick(); chk(extOut, 10'h201);
        $display("test out done");
    endtask
    // Sticky edges, bus trigger sets bit 0, read clears
    task automatic t_in;
        press(6'h1e);
        bus(1, `TEIO_A_CMD, 32'h2);
        bus(0, `TEIO_A_INEDGE, 0); chk(q, 32'h1f);
        bus(0, `TEIO_A_INEDGE, 0); chk(q, 32'h0);
        $display("test in done");
    endtask
    // Idle ignores, arm waits, one trigger, idle again, lock
    task automatic t_trigger_input_line;
        bus(0, `TEIO_A_STATUS, 0);
        bus(1, `TEIO_A_CMD, 32'h1); bus(0, `TEIO_A_STATUS, 0);
        chk(q[4], 1'b1);
        bus(1, `TEIO_A_CTRL, 32'h080); tick(40); state(0);
        press(6'h01); state(0);
        bus(1, `TEIO_A_CMD, 32'h1); state(1);
        press(6'h01);
        for (n = 0; n < 60 && strobe !== 1'b1; n++) tick();
        chk(strobe, 1'b1); state(0);
        bus(1, `TEIO_A_CTRL, 32'h081); bus(1, `TEIO_A_CMD, 32'h1);
        press(6'h01); tick(30); state(1);
        press(6'h20); tick(30); state(0);
        $display("test trigger_input_line done");
    endtask
    // Formatter selects, pulse current, backup image
    task automatic t_fmt;
        bus(1, `TEIO_A_CTRL, 32'h02a); tick();
        chk({hdr, termCr, curPulse}, 3'h7);
        bus(1, `TEIO_A_CMD, 32'h20); #1 chk(nvStore, 1'b1);
        chk(nvData, 32'ha2a);
        bus(1, `TEIO_A_CTRL, 32'h060); tick(2); chk(curPulse, 1'b0);
        $display("test fmt done");
    endtask
    // Pulse-mode strobe lasts pulse ms, here 2 x 10 cycles
    // Single shot, so no next start cuts the pulse short
    task automatic t_pulse;
        bus(1, `TEIO_A_PULSE, 32'h2); bus(1, `TEIO_A_CTRL, 32'h010);
        tick(20);
        for (n = 0; n < 200 && strobe !== 1'b0; n++) tick();
        bus(1, `TEIO_A_CMD, 32'h1);
        for (n = 0; n < 200 && strobe !== 1'b1; n++) tick();
        for (n = 0; n < 200 && strobe === 1'b1; n++) tick();
        chk(n, 20);
        $display("test pulse done");
    endtask
    // Panel save and load, empty slot, system reset
    task automatic t_panel;
        bus(1, `TEIO_A_CMD, 32'h340); bus(1, `TEIO_A_CTRL, 32'h02a);
        bus(1, `TEIO_A_CMD, 32'h380); bus(0, `TEIO_A_CTRL, 0);
        chk(q, 32'h018);
        bus(1, `TEIO_A_CMD, 32'h480); bus(0, `TEIO_A_STATUS, 0);
        chk(q[4], 1'b1);
        bus(1, `TEIO_A_CMD, 32'h10); bus(1, `TEIO_A_CMD, 32'h380);
        bus(0, `TEIO_A_CTRL, 0); chk(q, 32'h048);
        chk(extOut, 10'h0);
        $display("test panel done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        tick(2);
        bus(0, `TEIO_A_CTRL, 0); chk(q, 32'h040);
        t_out();
        t_in();
        t_trigger_input_line();
        t_fmt();
        t_pulse();
        t_panel();
        summarize();
    end
    // Hang guard, far beyond the expected run
    initial begin
        repeat (30000) @(posedge mclk);
        errTotal++;
        summarize();
    end
endmodule // teio_trigger_io_tb
